// ==== rtl/dop_pkg.sv ====
// Types shared by the dual output PWM design
package dop_pkg;

	// Control register fields
	typedef struct packed {
		logic [3:0] period_select;
		logic enable_b;
		logic enable_a;
		logic period_end_flag;
		logic irq_enable;
	} dop_ctrl_t;

	// One Wishbone request as seen by the slave
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [14:0] idx;
		logic [31:0] dat;
	} dop_wb_req_t;

	// Register decode result
	typedef enum logic [2:0] {
		DOP_SEL_NONE,
		DOP_SEL_A_EXTRA,
		DOP_SEL_A_WIDTH,
		DOP_SEL_B_EXTRA,
		DOP_SEL_B_WIDTH,
		DOP_SEL_CONTROL,
		DOP_SEL_PRESCALE,
		DOP_SEL_CLKSET
	} dop_sel_t;

endpackage : dop_pkg

// ==== rtl/dop_pwm_regs.svh ====
// Register indexes, field positions and reset values of the dual output PWM
`ifndef DOP_PWM_REGS_SVH
`define DOP_PWM_REGS_SVH

// Register indexes; the byte address is four times the index
`define DOP_IDX_A_EXTRA 15'h7FAA
`define DOP_IDX_A_WIDTH 15'h7FAB
`define DOP_IDX_B_EXTRA 15'h7FAC
`define DOP_IDX_B_WIDTH 15'h7FAD
`define DOP_IDX_CONTROL 15'h7FAE
`define DOP_IDX_PRESCALE 15'h7FAF
`define DOP_IDX_CLKSET 15'h7FB6

// Control register field positions
`define DOP_CTRL_PSEL_LSB 4
`define DOP_CTRL_ENB_BIT 3
`define DOP_CTRL_ENA_BIT 2
`define DOP_CTRL_OVF_BIT 1
`define DOP_CTRL_IRQ_BIT 0

// Extra pulse field sits in the upper nibble
`define DOP_EXTRA_LSB 4

// Clock setting register: count clock select bit
`define DOP_CLKSEL_BIT 0

// Reset value shared by every register
`define DOP_RESET_VAL 8'h00

// Low nibble that completes the fundamental counter terminal value
`define DOP_FUND_LOW_NIBBLE 4'hF

`endif

// ==== rtl/dop_pwm_top.sv ====
// Dual output 12-bit PWM with a classic Wishbone register slave
// Timing
// Bus: a request is taken when cyc and stb are high and ack is low
// Bus: writes land at the take edge, ack and read data one clock later
// Bus: a held request is not taken twice, ack is a single-cycle pulse
// Bus: byte address is four times the register index, low bits ignored
// Bus: unmapped indexes acknowledge, read zero and ignore writes
// Reset: synchronous; clears every register, counter and output
// Count clock: oscillator edges reach the prescaler two to three clocks late
// Outputs: each waveform lags the fundamental counter by one clock
// Interrupt: request level lags the flag and enable by one clock
// Flag: set when a period ends with the extra counter at fifteen
// Flag: a hardware set wins over a software clear in the same clock
// Limit: the oscillator must stay well below half the system clock
// Limit: switching the count clock while running may give one odd tick
// Limit: a width written mid-period waits for the next count zero
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "dop_pwm_regs.svh"

module dop_pwm_top #(
	parameter int ADR_W = 17
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [ADR_W-1:0] wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Alternate oscillator pin, asynchronous to clk_in
	input wire logic alternate_oscillator_in,
	// PWM outputs and interrupt request
	output logic output_a_out,
	output logic output_b_out,
	output logic irq_out
);

	// The register indexes need at least 15 bits above the byte lanes
	if (ADR_W < 17) begin : g_adr_check
		$error("dop_pwm_top: ADR_W must be at least 17");
	end

	// The control register layout must fill exactly one byte lane
	if ($bits(dop_pkg::dop_ctrl_t) != 8) begin : g_ctrl_check
		$error("dop_pwm_top: control register type must be 8 bits");
	end

	// Bus request and decode
	dop_pkg::dop_wb_req_t req;
	dop_pkg::dop_sel_t wr_sel;
	logic req_valid;
	logic wr_en;
	logic ack_reg;
	logic [31:0] rdata_next;
	logic [31:0] rdata_reg;

	// Software visible registers
	// The extra fields keep only the written upper nibble
	logic [7:0] width_a_reg;
	logic [7:0] width_b_reg;
	logic [3:0] extra_a_reg;
	logic [3:0] extra_b_reg;
	dop_pkg::dop_ctrl_t ctrl_reg;
	logic [7:0] prescale_reg;
	logic [7:0] clkset_reg;

	// Alternate oscillator synchroniser and edge detect
	// The edge detector resets low, the idle level of a stopped oscillator
	logic osc_meta_reg;
	logic osc_sync_reg;
	logic osc_prev_reg;
	logic osc_rise;

	// Counting chain
	// Prescaler and fundamental counters are eight bits wide to match the register fields
	logic running;
	logic count_en;
	logic tick;
	logic period_end;
	logic overall_end;
	logic [7:0] fund_top;
	logic [7:0] pre_cnt_reg;
	logic [7:0] fund_cnt_reg;
	logic [3:0] extra_cnt_reg;

	// Per output arrays used by the generate loop
	// Unpacked so each generate copy drives its own element
	logic [1:0] enable;
	logic [7:0] width_w [2];
	logic [3:0] extra_w [2];
	logic [7:0] match_buf_reg [2];
	logic out_reg [2];
	logic irq_reg;

	// Map a register index to its register
	// Shared by the write strobe and the read multiplexer
	function automatic dop_pkg::dop_sel_t decode(input logic [14:0] idx);
		case (idx)
			`DOP_IDX_A_EXTRA: decode = dop_pkg::DOP_SEL_A_EXTRA;
			`DOP_IDX_A_WIDTH: decode = dop_pkg::DOP_SEL_A_WIDTH;
			`DOP_IDX_B_EXTRA: decode = dop_pkg::DOP_SEL_B_EXTRA;
			`DOP_IDX_B_WIDTH: decode = dop_pkg::DOP_SEL_B_WIDTH;
			`DOP_IDX_CONTROL: decode = dop_pkg::DOP_SEL_CONTROL;
			`DOP_IDX_PRESCALE: decode = dop_pkg::DOP_SEL_PRESCALE;
			`DOP_IDX_CLKSET: decode = dop_pkg::DOP_SEL_CLKSET;
			default: decode = dop_pkg::DOP_SEL_NONE;
		endcase
	endfunction : decode

	// Bit-reversed period index below the field spreads extras evenly
	// Up to eight picked periods never sit next to each other
	function automatic logic extra_due(input logic [3:0] cnt, input logic [3:0] field);
		logic [3:0] rev;
		rev = {cnt[0], cnt[1], cnt[2], cnt[3]};
		extra_due = (rev < field);
	endfunction : extra_due

	// Gather the bus signals into one request
	// Address bits below the index are ignored; every access is one word
	assign req.cyc = wb_cyc_in;
	assign req.stb = wb_stb_in;
	assign req.we = wb_we_in;
	assign req.sel = wb_sel_in;
	assign req.idx = wb_adr_in[16:2];
	assign req.dat = wb_dat_in;

	// A request is taken once; the held request is ignored while ack shows
	// The master keeps cyc and stb up through the ack cycle, so without
	// this gate one request would be taken and written twice
	assign req_valid = req.cyc && req.stb && !ack_reg;
	assign wr_sel = decode(req.idx);
	assign wr_en = req_valid && req.we && req.sel[0];

	// Acknowledge every access one cycle after it is taken, mapped or not
	// No wait states: every take is answered on the very next clock
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req_valid;
		end
	end

	// Read multiplexer; unmapped addresses read zero
	// Decoded from the live request so the data is ready at the take edge
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (decode(req.idx))
			dop_pkg::DOP_SEL_A_EXTRA: rdata_next[7:0] = {extra_a_reg, 4'h0};
			dop_pkg::DOP_SEL_A_WIDTH: rdata_next[7:0] = width_a_reg;
			dop_pkg::DOP_SEL_B_EXTRA: rdata_next[7:0] = {extra_b_reg, 4'h0};
			dop_pkg::DOP_SEL_B_WIDTH: rdata_next[7:0] = width_b_reg;
			dop_pkg::DOP_SEL_CONTROL: rdata_next[7:0] = ctrl_reg;
			dop_pkg::DOP_SEL_PRESCALE: rdata_next[7:0] = prescale_reg;
			dop_pkg::DOP_SEL_CLKSET: rdata_next[7:0] = clkset_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// Read data is captured with the ack and held otherwise
	// Holding between accesses keeps the read bus stable for slow masters
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_reg <= 32'h0000_0000;
		end else if (req_valid) begin
			rdata_reg <= rdata_next;
		end
	end

	// Plain data registers; disabling outputs leaves them untouched
	// Only byte lane 0 carries data; other lanes are acked and dropped
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			width_a_reg <= `DOP_RESET_VAL;
			width_b_reg <= `DOP_RESET_VAL;
			extra_a_reg <= 4'h0;
			extra_b_reg <= 4'h0;
			prescale_reg <= `DOP_RESET_VAL;
			clkset_reg <= `DOP_RESET_VAL;
		end else if (wr_en) begin
			case (wr_sel)
				dop_pkg::DOP_SEL_A_EXTRA: extra_a_reg <= req.dat[`DOP_EXTRA_LSB +: 4];
				dop_pkg::DOP_SEL_A_WIDTH: width_a_reg <= req.dat[7:0];
				dop_pkg::DOP_SEL_B_EXTRA: extra_b_reg <= req.dat[`DOP_EXTRA_LSB +: 4];
				dop_pkg::DOP_SEL_B_WIDTH: width_b_reg <= req.dat[7:0];
				dop_pkg::DOP_SEL_PRESCALE: prescale_reg <= req.dat[7:0];
				// Switching the source mid-run may give one odd tick
				dop_pkg::DOP_SEL_CLKSET: clkset_reg <= req.dat[7:0];
				default: ;
			endcase
		end
	end

	// Control register; a hardware set of the flag beats a software clear
	// A read-modify-write that returns the flag as 1 leaves it set, so
	// updating other fields never loses a period end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl_reg <= dop_pkg::dop_ctrl_t'(`DOP_RESET_VAL);
		end else begin
			if (wr_en && wr_sel == dop_pkg::DOP_SEL_CONTROL) begin
				ctrl_reg.period_select <= req.dat[`DOP_CTRL_PSEL_LSB +: 4];
				ctrl_reg.enable_b <= req.dat[`DOP_CTRL_ENB_BIT];
				ctrl_reg.enable_a <= req.dat[`DOP_CTRL_ENA_BIT];
				ctrl_reg.irq_enable <= req.dat[`DOP_CTRL_IRQ_BIT];
				// Writing 0 clears the flag, writing 1 leaves it alone
				if (!req.dat[`DOP_CTRL_OVF_BIT]) begin
					ctrl_reg.period_end_flag <= 1'b0;
				end
			end
			if (overall_end) begin
				ctrl_reg.period_end_flag <= 1'b1;
			end
		end
	end

	// Two-stage synchroniser for the alternate oscillator pin
	// The first stage may go metastable; only the second stage is read
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
		end else begin
			osc_meta_reg <= alternate_oscillator_in;
			osc_sync_reg <= osc_meta_reg;
			osc_prev_reg <= osc_sync_reg;
		end
	end

	// Oscillator must run well below half of clk_in to be counted
	assign osc_rise = osc_sync_reg && !osc_prev_reg;

	// Count clock enable and run state
	// Both enables low hold the prescaler and fundamental counter at zero,
	// so a restart begins a clean fundamental period
	assign count_en = clkset_reg[`DOP_CLKSEL_BIT] ? osc_rise : 1'b1;
	assign running = ctrl_reg.enable_a || ctrl_reg.enable_b;
	assign tick = running && count_en && (pre_cnt_reg == prescale_reg);
	assign fund_top = {ctrl_reg.period_select, `DOP_FUND_LOW_NIBBLE};
	assign period_end = tick && (fund_cnt_reg == fund_top);
	assign overall_end = period_end && (extra_cnt_reg == 4'hF);

	// Prescaler: reset on its match or when stopped
	// A smaller value written while counting past it wraps through 255
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pre_cnt_reg <= 8'h00;
		end else if (!running) begin
			pre_cnt_reg <= 8'h00;
		end else if (tick) begin
			pre_cnt_reg <= 8'h00;
		end else if (count_en) begin
			pre_cnt_reg <= pre_cnt_reg + 8'h01;
		end
	end

	// Fundamental counter: one step per tick, wraps on period end
	// Terminal value {period_select, F} gives (period_select+1)*16 ticks
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fund_cnt_reg <= 8'h00;
		end else if (!running) begin
			fund_cnt_reg <= 8'h00;
		end else if (period_end) begin
			fund_cnt_reg <= 8'h00;
		end else if (tick) begin
			fund_cnt_reg <= fund_cnt_reg + 8'h01;
		end
	end

	// Extra pulse counter survives stops; only reset clears it
	// The extra-tick pattern therefore resumes where it left off
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			extra_cnt_reg <= 4'h0;
		end else if (period_end) begin
			extra_cnt_reg <= extra_cnt_reg + 4'h1;
		end
	end

	// Per output views for the generate loop
	// Index 0 is output a, index 1 is output b
	assign enable = {ctrl_reg.enable_b, ctrl_reg.enable_a};
	assign width_w[0] = width_a_reg;
	assign width_w[1] = width_b_reg;
	assign extra_w[0] = extra_a_reg;
	assign extra_w[1] = extra_b_reg;

	// Each output: buffered compare, optional extra tick, waveform
	// Both copies share the counters and differ only in their registers
	for (genvar i = 0; i < 2; i++) begin : g_out
		logic [8:0] eff_width;

		// Width plus one tick in the periods picked by the field
		// Nine bits so width 255 plus a due extra cannot wrap; that case
		// keeps the output high for a whole 256-tick period
		assign eff_width = {1'b0, match_buf_reg[i]}
			+ {8'h00, extra_due(extra_cnt_reg, extra_w[i])};

		// Buffer tracks the register when stopped, reloads at count zero
		// Loading only at count zero keeps a period from seeing two widths
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				match_buf_reg[i] <= 8'h00;
			end else if (!enable[i]) begin
				match_buf_reg[i] <= width_w[i];
			end else if (fund_cnt_reg == 8'h00) begin
				match_buf_reg[i] <= width_w[i];
			end
		end

		// High from count zero until the count reaches the width
		// Compared one clock after the counter, so the output lags by a clock
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				out_reg[i] <= 1'b0;
			end else if (!enable[i]) begin
				out_reg[i] <= 1'b0;
			end else begin
				out_reg[i] <= ({1'b0, fund_cnt_reg} < eff_width);
			end
		end
	end

	// Interrupt request level
	// Level only; vector routing lies outside this block
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= ctrl_reg.irq_enable && ctrl_reg.period_end_flag;
		end
	end

	// Outputs straight from flip-flops
	// These assigns only rename registers, no logic sits in between
	assign wb_ack_out = ack_reg;
	assign wb_dat_out = rdata_reg;
	assign output_a_out = out_reg[0];
	assign output_b_out = out_reg[1];
	assign irq_out = irq_reg;

endmodule : dop_pwm_top

`default_nettype wire

// ==== testbench/dop_pwm_properties.sv ====
// Port-level assertion checker for the dual output PWM block
`timescale 1ns/1ps
`default_nettype none
`include "dop_pwm_regs.svh"
module dop_pwm_properties #(
	parameter int ADR_W = 17
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [ADR_W-1:0] wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	// Oscillator and outputs
	input wire logic alternate_oscillator_in,
	input wire logic output_a_out,
	input wire logic output_b_out,
	input wire logic irq_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// A request taken at this edge
	sequence s_take;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	// A taken control write on the live byte lane
	sequence s_ctrl_wr;
		s_take ##0 (wb_we_in && wb_sel_in[0] && wb_adr_in[16:2] == `DOP_IDX_CONTROL);
	endsequence
	// A taken read of either extra pulse register
	sequence s_extra_rd;
		s_take ##0 (!wb_we_in && (wb_adr_in[16:2] == `DOP_IDX_A_EXTRA
			|| wb_adr_in[16:2] == `DOP_IDX_B_EXTRA));
	endsequence
	// A taken read of an unmapped index
	sequence s_unmapped_rd;
		s_take ##0 (!wb_we_in && wb_adr_in[16:2] == 15'h0000);
	endsequence
	// Both PWM outputs, the interrupt request and the ack low
	sequence s_quiet;
		!output_a_out && !output_b_out && !irq_out && !wb_ack_out;
	endsequence

	// Bus answers one cycle after the take, for exactly one cycle
	a_ack_follows: assert property (s_take |=> wb_ack_out)
		else $error("ack missing after request");
	a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	a_ack_no_req: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
		else $error("ack without request");
	a_extra_low_zero: assert property (s_extra_rd |=> wb_dat_out[3:0] == 4'h0)
		else $error("extra pulse low bits not zero");
	a_unmapped_zero: assert property (s_unmapped_rd |=> wb_dat_out == 32'h0)
		else $error("unmapped read not zero");
	// Registered outputs give two edges of slack after the write lands
	a_a_stops: assert property (s_ctrl_wr ##0 !wb_dat_in[2] |-> ##2 !output_a_out)
		else $error("output a high while stopped");
	a_b_stops: assert property (s_ctrl_wr ##0 !wb_dat_in[3] |-> ##2 !output_b_out)
		else $error("output b high while stopped");
	a_irq_masked: assert property (s_ctrl_wr ##0 !wb_dat_in[0] |-> ##2 !irq_out)
		else $error("irq high while disabled");
	// Reset itself is the cause here, so it must not disable the check
	a_reset_quiet: assert property (disable iff (1'b0) rst_in |=> s_quiet)
		else $error("outputs active after reset");
endmodule : dop_pwm_properties
`default_nettype wire

// ==== testbench/dop_pwm_top_bench.sv ====
// Self-checking bench for the dual output PWM block
`timescale 1ns/1ps
`default_nettype none
`include "dop_pwm_regs.svh"
module dop_pwm_top_bench;
	typedef struct packed {
		logic [14:0] idx;
		logic [7:0] wr;
		logic [7:0] rd;
	} dop_row_t;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic wb_cyc_in = 1'b0;
	logic wb_stb_in = 1'b0;
	logic wb_we_in = 1'b0;
	logic [3:0] wb_sel_in = 4'h0;
	logic [16:0] wb_adr_in = 17'h00000;
	logic [31:0] wb_dat_in = 32'h0;
	logic alt_osc = 1'b0;
	logic alt_run = 1'b0;
	logic [31:0] wb_dat_out;
	logic wb_ack_out;
	logic output_a_out;
	logic output_b_out;
	logic irq_out;
	logic [31:0] q;
	int fails = 0;
	int tests_run = 0;
	// Write value beside expected read-back; flag bit written 1 keeps its 0
	dop_row_t rows [8] = '{
		'{`DOP_IDX_A_EXTRA, 8'hFF, 8'hF0}, '{`DOP_IDX_A_WIDTH, 8'hA5, 8'hA5},
		'{`DOP_IDX_B_EXTRA, 8'h5F, 8'h50}, '{`DOP_IDX_B_WIDTH, 8'h3C, 8'h3C},
		'{`DOP_IDX_CONTROL, 8'hF3, 8'hF1}, '{`DOP_IDX_PRESCALE, 8'h81, 8'h81},
		'{`DOP_IDX_CLKSET, 8'hFE, 8'hFE}, '{15'h0000, 8'h5A, 8'h00}};

	dop_pwm_top dut (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
		.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_sel_in(wb_sel_in),
		.wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
		.wb_ack_out(wb_ack_out), .alternate_oscillator_in(alt_osc),
		.output_a_out(output_a_out), .output_b_out(output_b_out), .irq_out(irq_out));

	// 20 MHz system clock
	initial begin
		forever #25 clk_in = ~clk_in;
	end
	// Oscillator stand-in: a rising edge every second clock once started
	always @(posedge clk_in) begin
		if (alt_run) alt_osc <= ~alt_osc;
	end

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One classic cycle; held until ack is sampled, a lost ack ends the run
	task automatic wb(input logic we, input logic [14:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_sel_in <= 4'h1;
		wb_adr_in <= {idx, 2'b00};
		wb_dat_in <= {24'h0, d};
		do begin
			@(posedge clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 16);
		if (wb_ack_out !== 1'b1) begin
			chk("bus ack", 32'h1, {31'h0, wb_ack_out});
			give_verdict();
		end
		q = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask : wb

	task automatic count_high(input int n, output int ca, output int cb);
		ca = 0;
		cb = 0;
		repeat (n) begin
			@(posedge clk_in);
			ca += int'(output_a_out === 1'b1);
			cb += int'(output_b_out === 1'b1);
		end
	endtask : count_high

	// Width 4 on both outputs, B gets half of its periods extended
	task automatic run_pwm(input logic [7:0] ctl, csel, pre, input int ea, eb);
		int ca;
		int cb;
		wb(1'b1, `DOP_IDX_CLKSET, csel);
		wb(1'b1, `DOP_IDX_PRESCALE, pre);
		wb(1'b1, `DOP_IDX_A_WIDTH, 8'h04);
		wb(1'b1, `DOP_IDX_A_EXTRA, 8'h00);
		wb(1'b1, `DOP_IDX_B_WIDTH, 8'h04);
		wb(1'b1, `DOP_IDX_B_EXTRA, 8'h80);
		wb(1'b1, `DOP_IDX_CONTROL, ctl);
		repeat (40) @(posedge clk_in);
		count_high(1024, ca, cb);
		chk("high time a", ea, ca);
		chk("high time b", eb, cb);
	endtask : run_pwm

	initial begin
		int ca;
		int cb;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		foreach (rows[i]) begin
			wb(1'b0, rows[i].idx, 8'h00);
			chk("reset value", 32'h0, q);
			wb(1'b1, rows[i].idx, rows[i].wr);
			wb(1'b0, rows[i].idx, 8'h00);
			chk("register", {24'h0, rows[i].rd}, q);
		end
		$display("test registers done");
		wb(1'b1, `DOP_IDX_CONTROL, 8'h00);
		run_pwm(8'h0C, 8'h00, 8'h01, 256, 288);
		// Stop with flag kept and interrupt enabled
		wb(1'b1, `DOP_IDX_CONTROL, 8'h03);
		repeat (3) @(posedge clk_in);
		chk("stopped outputs", 32'h0, {30'h0, output_a_out, output_b_out});
		chk("irq raised", 32'h1, {31'h0, irq_out});
		wb(1'b0, `DOP_IDX_CONTROL, 8'h00);
		chk("flag set", 32'h03, q);
		wb(1'b1, `DOP_IDX_CONTROL, 8'h01);
		wb(1'b0, `DOP_IDX_CONTROL, 8'h00);
		chk("flag cleared", 32'h01, q);
		repeat (3) @(posedge clk_in);
		chk("irq cleared", 32'h0, {31'h0, irq_out});
		$display("test system clock done");
		alt_run <= 1'b1;
		run_pwm(8'h1C, 8'h01, 8'h00, 128, 144);
		$display("test oscillator clock done");
		// Reset in mid-run: both outputs are still running here
		rst_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		chk("in reset", 32'h0, {29'h0, output_a_out, output_b_out, irq_out});
		rst_in <= 1'b0;
		alt_run <= 1'b0;
		count_high(64, ca, cb);
		chk("high after reset", 32'h0, ca + cb);
		wb(1'b0, `DOP_IDX_CONTROL, 8'h00);
		chk("control after reset", 32'h0, q);
		wb(1'b0, `DOP_IDX_B_EXTRA, 8'h00);
		chk("extra after reset", 32'h0, q);
		wb(1'b0, `DOP_IDX_CLKSET, 8'h00);
		chk("clock select after reset", 32'h0, q);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule : dop_pwm_top_bench

bind dop_pwm_top dop_pwm_properties #(.ADR_W(ADR_W)) u_props (.clk_in(clk_in),
	.rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
	.wb_sel_in(wb_sel_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
	.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
	.alternate_oscillator_in(alternate_oscillator_in), .output_a_out(output_a_out),
	.output_b_out(output_b_out), .irq_out(irq_out));
`default_nettype wire
